// ### logic/cxu_pkg.sv
// Constants, mode codes and mode decoding for the capture/compare/pulse unit.
// Assumes a single system clock domain and plain-port control access.
package cxu_pkg;

    // ========================================
    // Mode select codes
    typedef enum logic [3:0]
    {
        CXU_MODE_OFF = 4'b0000,
        CXU_MODE_CAP_FALL = 4'b0100,
        CXU_MODE_CAP_RISE = 4'b0101,
        CXU_MODE_CAP_RISE4 = 4'b0110,
        CXU_MODE_CAP_RISE16 = 4'b0111,
        CXU_MODE_CMP_SET = 4'b1000,
        CXU_MODE_CMP_CLR = 4'b1001,
        CXU_MODE_CMP_SWI = 4'b1010,
        CXU_MODE_CMP_SEV = 4'b1011
    } cxu_mode_t;

    // ========================================
    // Unit control field layout and reset values
    localparam int CTRL_W = 6;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 3;
    localparam int DUTY_LSB = 4;
    localparam int DUTY_MSB = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] DUTY_BITS_RST = 2'h0;
    localparam logic [3:0] PRESCALE_RST = 4'h0;
    localparam logic [1:0] PHASE_RST = 2'h0;
    localparam logic [1:0] T2_PRESCALE_1TO1 = 2'h0;

    // ========================================
    // Capture prescale counts
    localparam logic [3:0] PRESCALE_LAST4 = 4'h3;
    localparam logic [3:0] PRESCALE_LAST16 = 4'hf;

    // ========================================
    // Mode decoding
    function automatic logic is_capture(input logic [3:0] m);
        is_capture = (m[3:2] == 2'h1);
    endfunction

    function automatic logic is_compare(input logic [3:0] m);
        is_compare = (m[3:2] == 2'h2);
    endfunction

    function automatic logic is_pwm(input logic [3:0] m);
        is_pwm = (m[3:2] == 2'h3);
    endfunction

endpackage

// ### logic/cxu_capture_edge.sv
// Pin synchroniser, edge detector and capture prescaler.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ps
module cxu_capture_edge
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control
    input wire logic hold,
    input wire logic clear,
    input wire logic [1:0] edge_sel,
    // Pin
    input wire logic pin_in,
    // Event
    output logic capture_pulse
);

    // ========================================
    // Synchroniser
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic [3:0] count_q;
    logic [3:0] count_d;
    wire rise = sync2_q & ~prev_q;
    wire fall = ~sync2_q & prev_q;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            prev_q <= 1'b0;
        else if (!hold)
            prev_q <= sync2_q;
    end

    // ========================================
    // Prescaler
    // Cleared outside capture
    assign count_d = clear ? cxu_pkg::PRESCALE_RST :
                     (rise ? count_q + 4'h1 : count_q);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            count_q <= cxu_pkg::PRESCALE_RST;
        else if (!hold)
            count_q <= count_d;
    end

    wire last4 = (count_q[1:0] == cxu_pkg::PRESCALE_LAST4[1:0]);
    wire last16 = (count_q == cxu_pkg::PRESCALE_LAST16);
    assign capture_pulse = ~clear & ~hold &
                           ((edge_sel == 2'h0) ? fall :
                            (edge_sel == 2'h1) ? rise :
                            (edge_sel == 2'h2) ? (rise & last4) : (rise & last16));

    // ========================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    chk_prescale_cleared: assert property (clear && !hold |=> count_q == 4'h0)
        else $error("prescaler not cleared");
    chk_fourth_rise: assert property (
        rise && !clear && !hold && edge_sel == 2'h2 |-> capture_pulse == last4)
        else $error("every fourth rising edge wrong");
    chk_fall_capture: assert property (
        fall && !clear && !hold && edge_sel == 2'h0 |-> capture_pulse)
        else $error("falling edge missed");

endmodule

// ### logic/cxu_top.sv
// Capture/compare/pulse-width unit: capture, compare actions and pulse output.
// Assumes timers, port mux and converter live outside on the same clock.
`timescale 1ns/1ps
module cxu_top
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Unit control write and readback
    input wire logic ctrl_wr,
    input wire logic [5:0] ctrl_wdata,
    output logic [5:0] unit_control,
    // Capture/compare byte pair access
    input wire logic low_wr,
    input wire logic [7:0] low_wdata,
    input wire logic high_wr,
    input wire logic [7:0] high_wdata,
    output logic [7:0] capture_low_byte,
    output logic [7:0] capture_high_byte,
    // Flag
    input wire logic irq_clear,
    output logic unit_irq_flag,
    // Timer one
    input wire logic [15:0] timer_one_count,
    input wire logic timer_one_tick,
    output logic timer_one_reset,
    // Converter
    input wire logic adc_enable,
    output logic special_event,
    output logic adc_start,
    // Timer two
    input wire logic [7:0] timer_two_count,
    input wire logic [7:0] timer_two_period,
    input wire logic timer_two_inc,
    input wire logic [1:0] timer_two_prescale,
    input wire logic [1:0] prescale_low_bits,
    output logic timer_two_clear,
    // Power
    input wire logic sleep,
    // Pin
    input wire logic unit_pin_in,
    output logic unit_pin_out,
    output logic unit_pin_own
);

    // ========================================
    // State
    logic [3:0] mode_q;
    logic [1:0] duty_bits_q;
    logic [7:0] low_q;
    logic [7:0] high_q;
    logic [1:0] duty_latch_q;
    logic cmp_latch_q;
    logic pwm_q;
    logic flag_q;
    logic match_q;
    logic [1:0] phase_q;
    logic capture_pulse;
    logic [5:0] ctrl_d;

    // ========================================
    // Mode decode
    // Mode field decode
    wire cap_mode = cxu_pkg::is_capture(mode_q);
    wire cmp_mode = cxu_pkg::is_compare(mode_q);
    wire pwm_mode = cxu_pkg::is_pwm(mode_q);
    wire pwm_low_active = pwm_mode & mode_q[1];
    wire sev_mode = (mode_q == cxu_pkg::CXU_MODE_CMP_SEV);
    wire ctrl_zero = ctrl_wr & (ctrl_wdata == cxu_pkg::CTRL_RST);
    wire run = ~sleep;

    assign unit_control = {duty_bits_q, mode_q};
    assign capture_low_byte = low_q;
    assign capture_high_byte = high_q;
    assign unit_irq_flag = flag_q;

    // ========================================
    // Control register
    assign ctrl_d = ctrl_wr ? ctrl_wdata : {duty_bits_q, mode_q};

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= cxu_pkg::CTRL_RST[cxu_pkg::MODE_MSB:cxu_pkg::MODE_LSB];
            duty_bits_q <= cxu_pkg::CTRL_RST[cxu_pkg::DUTY_MSB:cxu_pkg::DUTY_LSB];
        end
        else if (run)
        begin
            mode_q <= ctrl_d[cxu_pkg::MODE_MSB:cxu_pkg::MODE_LSB];
            duty_bits_q <= ctrl_d[cxu_pkg::DUTY_MSB:cxu_pkg::DUTY_LSB];
        end
    end

    // ========================================
    // Capture path
    // Raw pin level feeds detector
    cxu_capture_edge u_edge
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .hold(sleep),
        .clear(~cap_mode),
        .edge_sel(mode_q[1:0]),
        .pin_in(unit_pin_in),
        .capture_pulse(capture_pulse)
    );

    // ========================================
    // Compare path
    // Continuous 16-bit compare
    wire match = ({high_q, low_q} == timer_one_count);
    wire match_rise = cmp_mode & match & ~match_q;

    assign special_event = sev_mode & match;
    assign adc_start = special_event & adc_enable & run;
    // Reset only if match still holds
    assign timer_one_reset = special_event & timer_one_tick & run;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            match_q <= 1'b0;
        else if (run)
            match_q <= match & cmp_mode;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            cmp_latch_q <= 1'b0;
        else if (run)
        begin
            if (ctrl_zero)
                cmp_latch_q <= 1'b0;
            else if (match_rise && mode_q == cxu_pkg::CXU_MODE_CMP_SET)
                cmp_latch_q <= 1'b1;
            else if (match_rise && mode_q == cxu_pkg::CXU_MODE_CMP_CLR)
                cmp_latch_q <= 1'b0;
        end
    end

    // ========================================
    // Flag
    // Sticky, set wins over clear
    wire flag_set = capture_pulse | match_rise;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            flag_q <= 1'b0;
        else if (run)
            flag_q <= flag_set | (flag_q & ~irq_clear);
    end

    // ========================================
    // Pulse-width time base
    // Low bits from phase or prescaler
    wire [1:0] base_low = (timer_two_prescale == cxu_pkg::T2_PRESCALE_1TO1) ?
                          phase_q : prescale_low_bits;
    wire [9:0] time_base = {timer_two_count, base_low};
    wire [9:0] slave_duty = {high_q, duty_latch_q};
    wire [9:0] master_duty = {low_q, duty_bits_q};
    wire period_end = pwm_mode & run & timer_two_inc & (timer_two_count == timer_two_period);
    wire duty_hit = pwm_mode & run & (time_base == slave_duty);

    assign timer_two_clear = period_end;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            phase_q <= cxu_pkg::PHASE_RST;
        else if (run)
            phase_q <= phase_q + 2'h1;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            pwm_q <= 1'b0;
        else if (ctrl_zero && run)
            pwm_q <= 1'b0;
        else if (period_end)
            pwm_q <= (master_duty != 10'h000);
        else if (duty_hit)
            pwm_q <= 1'b0;
    end

    // ========================================
    // Byte pair and duty buffer
    // Capture copies timer-one
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            low_q <= cxu_pkg::BYTE_RST;
            high_q <= cxu_pkg::BYTE_RST;
            duty_latch_q <= cxu_pkg::DUTY_BITS_RST;
        end
        else if (run)
        begin
            if (capture_pulse)
            begin
                low_q <= timer_one_count[7:0];
                high_q <= timer_one_count[15:8];
            end
            else
            begin
                if (low_wr)
                    low_q <= low_wdata;
                if (period_end)
                begin
                    high_q <= low_q;
                    duty_latch_q <= duty_bits_q;
                end
                else if (high_wr && !pwm_mode)
                    high_q <= high_wdata;
            end
        end
    end

    // ========================================
    // Pin drive
    // Soft interrupt leaves pin
    wire cmp_drive = (mode_q == cxu_pkg::CXU_MODE_CMP_SET) |
                     (mode_q == cxu_pkg::CXU_MODE_CMP_CLR);
    assign unit_pin_own = cmp_drive | pwm_mode;
    assign unit_pin_out = pwm_mode ? (pwm_q ^ pwm_low_active) : cmp_latch_q;

    // ========================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_period_end;
        period_end && !capture_pulse;
    endsequence

    sequence s_slave_loaded;
        ##1 high_q == $past(low_q) && duty_latch_q == $past(duty_bits_q);
    endsequence

    chk_capture_value: assert property (capture_pulse && run |=>
        {high_q, low_q} == $past(timer_one_count))
        else $error("capture value wrong");
    chk_capture_flag: assert property (capture_pulse && run |=> flag_q)
        else $error("capture did not set flag");
    chk_flag_sticky: assert property (flag_q && !irq_clear |=> flag_q)
        else $error("flag dropped without clear");
    chk_compare_flag: assert property (match_rise && run |=> flag_q)
        else $error("compare match did not set flag");
    chk_swint_pin: assert property (mode_q == cxu_pkg::CXU_MODE_CMP_SWI |-> !unit_pin_own)
        else $error("soft interrupt mode drives pin");
    chk_sev_reset: assert property (sev_mode && match && timer_one_tick && run
        |-> timer_one_reset && special_event)
        else $error("trigger reset missing");
    chk_reset_needs_match: assert property (timer_one_reset |-> match && sev_mode)
        else $error("timer reset without match");
    chk_zero_ctrl: assert property (ctrl_zero && run |=> !cmp_latch_q && !unit_pin_own)
        else $error("zero control did not clear latch");
    chk_slave_load: assert property (s_period_end |-> s_slave_loaded)
        else $error("slave duty not loaded at period end");
    chk_duty_clear: assert property (duty_hit && !period_end && !ctrl_zero |=> !pwm_q)
        else $error("pin not cleared on duty match");
    chk_sleep_hold: assert property (sleep ##1 sleep |-> $stable(unit_pin_out))
        else $error("pin changed during sleep");

    sequence s_set_match;
        match_rise && run && !ctrl_zero && mode_q == cxu_pkg::CXU_MODE_CMP_SET;
    endsequence

    sequence s_clr_match;
        match_rise && run && !ctrl_zero && mode_q == cxu_pkg::CXU_MODE_CMP_CLR;
    endsequence

    sequence s_period_set;
        period_end && !ctrl_zero && master_duty != 10'h000;
    endsequence

    sequence s_high_refused;
        pwm_mode && run && high_wr && !period_end;
    endsequence

    sequence s_asleep;
        sleep ##1 sleep;
    endsequence

    chk_cmp_set: assert property (s_set_match |=> cmp_latch_q)
        else $error("compare set action missing");
    chk_cmp_clr: assert property (s_clr_match |=> !cmp_latch_q)
        else $error("compare clear action missing");
    chk_sev_pin: assert property (sev_mode |-> !unit_pin_own)
        else $error("trigger mode drives pin");
    chk_adc_start: assert property (adc_start |-> special_event && adc_enable)
        else $error("conversion start without trigger");
    chk_sev_skip: assert property (!match |-> !timer_one_reset && !special_event)
        else $error("trigger without match");
    chk_flag_clear: assert property (flag_q && irq_clear && !flag_set && run |=> !flag_q)
        else $error("flag not cleared");
    chk_pwm_set: assert property (s_period_set |=> pwm_q)
        else $error("pin not set at period end");
    chk_high_locked: assert property (s_high_refused |=> $stable(high_q))
        else $error("slave duty written in pulse mode");
    chk_off_release: assert property (mode_q == cxu_pkg::CXU_MODE_OFF |-> !unit_pin_own)
        else $error("pin owned while off");
    chk_period_clear: assert property (timer_two_clear |-> pwm_mode && timer_two_inc)
        else $error("timer-two clear outside period end");
    chk_sleep_state: assert property (s_asleep |-> $stable(flag_q) && $stable(mode_q))
        else $error("unit state changed during sleep");

endmodule

// ### bench/cxu_pin_model.sv
// Wire model of the unit pin: unit driver, port latch and outside source.
// Assumes all drivers are levels; no pull on the wire.
`timescale 1ns/1ps
module cxu_pin_model
(
    // Unit side
    input wire logic pin_own,
    input wire logic pin_out,
    // Port latch and outside source
    input wire logic port_drive,
    input wire logic port_latch,
    input wire logic ext_level,
    // Resolved wire
    output logic pin_wire
);
    // ========================================
    // Wire resolution
    // port writes seen
    assign pin_wire = pin_own ? pin_out : (port_drive ? port_latch : ext_level);
endmodule

// ### bench/cxu_top_tb.sv
// Self-checking bench for the capture/compare/pulse unit.
// Assumes timers and converter are played by the bench on core_clk.
`timescale 1ns/1ps
module cxu_top_tb;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic ctrl_wr = 1'b0, low_wr = 1'b0, high_wr = 1'b0, irq_clear = 1'b0;
    logic [5:0] ctrl_wdata = 6'h00;
    logic [7:0] low_wdata = 8'h00, high_wdata = 8'h00;
    logic [15:0] t1 = 16'h0100;
    logic t1_tick = 1'b0, adc_en = 1'b1, t2_inc = 1'b0, sleep = 1'b0;
    logic [7:0] t2 = 8'h00, t2_per = 8'h03;
    logic [1:0] t2_ps = 2'h1, ps_low = 2'h0;
    logic port_drive = 1'b0, port_latch = 1'b0, ext_level = 1'b0;
    logic [5:0] unit_control;
    logic [7:0] lo_b, hi_b;
    logic flag, t1_rst, sev, adc_go, t2_clr, pin_out, pin_own, pin_wire;
    int bad_count = 0, n_tests = 0, cyc = 0;

    always #4 core_clk = ~core_clk;

    cxu_top i_cxu_top (.core_clk(core_clk), .resetn(resetn), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .unit_control(unit_control), .low_wr(low_wr),
        .low_wdata(low_wdata), .high_wr(high_wr), .high_wdata(high_wdata),
        .capture_low_byte(lo_b), .capture_high_byte(hi_b), .irq_clear(irq_clear),
        .unit_irq_flag(flag), .timer_one_count(t1), .timer_one_tick(t1_tick),
        .timer_one_reset(t1_rst), .adc_enable(adc_en), .special_event(sev),
        .adc_start(adc_go), .timer_two_count(t2), .timer_two_period(t2_per),
        .timer_two_inc(t2_inc), .timer_two_prescale(t2_ps),
        .prescale_low_bits(ps_low), .timer_two_clear(t2_clr), .sleep(sleep),
        .unit_pin_in(pin_wire), .unit_pin_out(pin_out), .unit_pin_own(pin_own));

    cxu_pin_model i_cxu_pin_model (.pin_own(pin_own), .pin_out(pin_out),
        .port_drive(port_drive), .port_latch(port_latch), .ext_level(ext_level),
        .pin_wire(pin_wire));

    // ========================================
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic edges(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input int sel, input logic [7:0] v);
        @(posedge core_clk);
        ctrl_wr <= (sel == 0);
        low_wr <= (sel == 1);
        high_wr <= (sel == 2);
        ctrl_wdata <= v[5:0];
        low_wdata <= v;
        high_wdata <= v;
        @(posedge core_clk);
        ctrl_wr <= 1'b0;
        low_wr <= 1'b0;
        high_wr <= 1'b0;
        edges(1);
    endtask

    task automatic clr_flag();
        @(posedge core_clk);
        irq_clear <= 1'b1;
        @(posedge core_clk);
        irq_clear <= 1'b0;
        edges(1);
    endtask

    task automatic pin(input logic v);
        @(posedge core_clk);
        ext_level <= v;
        edges(6);
    endtask

    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ========================================
    // Scenarios
    task automatic t_reset();
        check({unit_control, flag, pin_own, pin_out}, 16'h0000);
        check({hi_b, lo_b}, 16'h0000);
    endtask

    task automatic t_modes();
        logic [3:0] codes [10] = '{4'h0, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
        logic own_exp [10] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 10; i++)
        begin
            wr(0, {4'h0, codes[i]});
            check(unit_control, {2'h0, codes[i]});
            check(pin_own, own_exp[i]);
        end
        wr(0, 8'h00);
        check({pin_own, pin_out}, 2'b00);
    endtask

    task automatic t_capture();
        wr(0, 8'h05);
        t1 <= 16'h1234;
        pin(1'b1);
        check({hi_b, lo_b}, 16'h1234);
        check(flag, 1'b1);
        pin(1'b0);
        check({hi_b, lo_b}, 16'h1234);
        t1 <= 16'h5678;
        pin(1'b1);
        check({hi_b, lo_b}, 16'h5678);
        wr(0, 8'h04);
        t1 <= 16'h9abc;
        pin(1'b0);
        check({hi_b, lo_b}, 16'h9abc);
        wr(0, 8'h00);
        wr(0, 8'h06);
        clr_flag();
        check(flag, 1'b0);
        for (int i = 1; i <= 4; i++)
        begin
            t1 <= 16'h0a00 + 16'(i);
            pin(1'b1);
            check(flag, logic'(i == 4));
            pin(1'b0);
        end
        check({hi_b, lo_b}, 16'h0a04);
        wr(0, 8'h00);
        wr(0, 8'h05);
        clr_flag();
        port_latch <= 1'b1;
        port_drive <= 1'b1;
        t1 <= 16'h4321;
        edges(6);
        check({flag, hi_b, lo_b}, {1'b1, 16'h4321});
        port_drive <= 1'b0;
        wr(0, 8'h00);
        clr_flag();
        pin(1'b1);
        check(flag, 1'b0);
    endtask

    task automatic t_compare();
        t1 <= 16'h0100;
        wr(1, 8'h34);
        wr(2, 8'h02);
        wr(0, 8'h08);
        t1 <= 16'h0234;
        edges(2);
        check({flag, pin_own, pin_out}, 3'b111);
        t1 <= 16'h0100;
        wr(0, 8'h09);
        t1 <= 16'h0234;
        edges(2);
        check({pin_own, pin_out}, 2'b10);
        t1 <= 16'h0100;
        wr(0, 8'h08);
        t1 <= 16'h0234;
        edges(2);
        wr(0, 8'h00);
        check(pin_out, 1'b0);
        clr_flag();
        t1 <= 16'h0100;
        wr(0, 8'h0a);
        t1 <= 16'h0234;
        edges(2);
        check({flag, pin_own, sev}, 3'b100);
        clr_flag();
        t1 <= 16'h0100;
        wr(0, 8'h0b);
        t1 <= 16'h0234;
        edges(1);
        check({sev, adc_go, t1_rst, pin_own}, 4'b1100);
        t1_tick <= 1'b1;
        edges(1);
        check({t1_rst, flag}, 2'b11);
        t1_tick <= 1'b0;
        t1 <= 16'h0000;
        edges(1);
        check({sev, t1_rst}, 2'b00);
        t1 <= 16'h0234;
        low_wr <= 1'b1;
        low_wdata <= 8'h35;
        @(posedge core_clk);
        low_wr <= 1'b0;
        t1_tick <= 1'b1;
        edges(1);
        check({sev, t1_rst}, 2'b00);
        t1_tick <= 1'b0;
        wr(0, 8'h00);
    endtask

    task automatic t_pwm();
        t2 <= 8'h00;
        wr(0, 8'h0c);
        wr(1, 8'h01);
        wr(2, 8'haa);
        check(hi_b, 8'h02);
        t2 <= 8'h03;
        t2_inc <= 1'b1;
        edges(1);
        check(t2_clr, 1'b1);
        t2_inc <= 1'b0;
        t2 <= 8'h00;
        edges(1);
        check({pin_own, pin_out, hi_b}, {2'b11, 8'h01});
        ps_low <= 2'h1;
        t2 <= 8'h01;
        edges(2);
        check(pin_out, 1'b1);
        ps_low <= 2'h0;
        edges(2);
        check(pin_out, 1'b0);
        sleep <= 1'b1;
        wr(0, 8'h05);
        check(unit_control, 6'h0c);
        sleep <= 1'b0;
        wr(0, 8'h00);
        check({unit_control, pin_own}, 7'h00);
    endtask

    // ========================================
    // Sequence and watchdog
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            close_out();
        end
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        edges(1);
        t_reset();
        t_modes();
        t_capture();
        t_compare();
        t_pwm();
        close_out();
    end
endmodule
